/* design/can_irq_ctrl.sv */
// Interrupt flags and masks, configuration handshake and power-down control.
// Assumes the protocol engine shares sys_clk and delivers one-cycle events;
// the bus receive pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
module can_irq_ctrl (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire can_irq_pkg::core_evt_t core_evt,
    input  wire logic                   can_rx,
    input  wire logic                   irq_ack,
    output logic                        mailbox_irq_line_n,
    output logic                        mailbox_prio_line,
    output logic                        error_irq_line_n,
    output logic                        error_prio_line,
    output logic                        bitcfg_write_ok,
    output logic                        bus_active,
    output logic                        err_cnt_clear
);

    // Write-one-to-clear with set winning over clear
    function automatic logic [15:0] w1c(input logic [15:0] cur, input logic [15:0] clr,
                                        input logic [15:0] set);
        w1c = (cur & ~clr) | set;
    endfunction

    // APB side state
    logic [31:0] prdata_reg,  prdata_next;
    logic        pready_reg,  pready_next;
    logic        pslverr_reg, pslverr_next;

    // Block state
    logic [15:0] flag_reg,   flag_next;
    logic [15:0] mask_reg,   mask_next;
    logic [3:0]  ta_reg,     ta_next;
    logic [3:0]  rmp_reg,    rmp_next;
    logic        ccr_reg,    ccr_next;
    logic        cce_reg,    cce_next;
    logic        pdr_reg,    pdr_next;
    logic        pda_reg,    pda_next;
    logic        wake_on_activity_reg,   wake_on_activity_next;
    logic [3:0]  recess_reg, recess_next;
    logic        busoff_reg, passive_reg;
    logic        rx_meta_reg, rx_sync_reg;
    logic        mirq_reg, mirq_next, eirq_reg, eirq_next;
    logic        mpri_reg, mpri_next, epri_reg, epri_next;
    logic        ok_reg, ok_next, act_reg, act_next, clr_reg, clr_next;
    can_irq_pkg::pd_state_t pd_reg, pd_next;

    logic [15:0] index;
    logic        wr_en;
    logic [5:0]  mbx_evt;
    logic [15:0] set_vec, clr_vec, wdat;
    logic        rx_dominant;

    assign index       = paddr[17:2];
    assign wr_en       = psel & penable & pready_reg & pwrite;
    assign wdat        = pwdata[15:0];
    assign rx_dominant = ~rx_sync_reg;

    // Pin synchroniser; the wake path applies no glitch filter beyond this
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= can_rx;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // APB answer: ready in the first access cycle, no wait states
    always_comb begin
        pready_next  = psel & ~penable & ~pready_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        if (psel & ~penable) begin
            prdata_next = 32'h0000_0000;
            case (index)
                can_irq_pkg::IDX_FLAG:   prdata_next[15:0] = flag_reg;
                can_irq_pkg::IDX_MASK:   prdata_next[15:0] = mask_reg;
                can_irq_pkg::IDX_CTRL: begin
                    prdata_next[can_irq_pkg::BIT_CCR]  = ccr_reg;
                    prdata_next[can_irq_pkg::BIT_PDR]  = pdr_reg;
                    prdata_next[can_irq_pkg::BIT_WAKE_ON_ACTIVITY] = wake_on_activity_reg;
                end
                can_irq_pkg::IDX_STATUS: begin
                    prdata_next[can_irq_pkg::BIT_CCE] = cce_reg;
                    prdata_next[can_irq_pkg::BIT_PDA] = pda_reg;
                end
                can_irq_pkg::IDX_TXACK:  prdata_next[can_irq_pkg::TA_LSB +: 4] = ta_reg;
                can_irq_pkg::IDX_RXPEND: prdata_next[can_irq_pkg::RMP_LSB +: 4] = rmp_reg;
                default:                 pslverr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Flags, masks, control and power-down sequencing
    always_comb begin
        flag_next   = flag_reg;
        mask_next   = mask_reg;
        ta_next     = ta_reg;
        rmp_next    = rmp_reg;
        ccr_next    = ccr_reg;
        cce_next    = cce_reg;
        pdr_next    = pdr_reg;
        pda_next    = pda_reg;
        wake_on_activity_next   = wake_on_activity_reg;
        recess_next = recess_reg;
        pd_next     = pd_reg;
        clr_next    = 1'b0;
        set_vec     = 16'h0000;
        clr_vec     = 16'h0000;

        // Mailbox events: TA covers mailboxes 2-5, RX_PENDING_BITS mailboxes 0-3
        // Auto-answer and remote-request completions come in on the same strobes
        mbx_evt = {core_evt.ta_set, 2'b00} | {2'b00, core_evt.rmp_set};
        set_vec[can_irq_pkg::MBX_LSB +: 6] = mbx_evt &
                                             mask_reg[can_irq_pkg::MBX_LSB +: 6];
        set_vec[can_irq_pkg::BIT_WARN]    = (core_evt.tec >= can_irq_pkg::WARN_LEVEL) |
                                            (core_evt.rec >= can_irq_pkg::WARN_LEVEL);
        set_vec[can_irq_pkg::BIT_PASSIVE] = core_evt.passive & ~passive_reg;
        set_vec[can_irq_pkg::BIT_BUSOFF]  = core_evt.busoff & ~busoff_reg;
        set_vec[can_irq_pkg::BIT_WAKE]    = (pd_reg == can_irq_pkg::PD_SLEEP) &
                                            rx_dominant;
        set_vec[can_irq_pkg::BIT_WDENY]   = core_evt.write_denied;
        set_vec[can_irq_pkg::BIT_ABORT]   = core_evt.abort_done;
        set_vec[can_irq_pkg::BIT_LOST]    = core_evt.msg_lost;

        // Clears: error flags by flag write, mailbox flags only via TA or RX_PENDING_BITS
        // irq_ack takes no part here, so acknowledges never touch flags
        if (wr_en && index == can_irq_pkg::IDX_FLAG) begin
            clr_vec[can_irq_pkg::ERR_N-1:0] = wdat[can_irq_pkg::ERR_N-1:0];
        end
        if (wr_en && index == can_irq_pkg::IDX_TXACK) begin
            clr_vec[can_irq_pkg::MBX_LSB+2 +: 4] = wdat[can_irq_pkg::TA_LSB +: 4];
        end
        if (wr_en && index == can_irq_pkg::IDX_RXPEND) begin
            clr_vec[can_irq_pkg::MBX_LSB +: 4] = clr_vec[can_irq_pkg::MBX_LSB +: 4] |
                                                 wdat[can_irq_pkg::RMP_LSB +: 4];
        end
        flag_next = w1c(flag_reg, clr_vec, set_vec) & can_irq_pkg::FLAG_WMASK;
        if (wr_en && index == can_irq_pkg::IDX_TXACK) begin
            ta_next = ta_reg & ~wdat[can_irq_pkg::TA_LSB +: 4];
        end
        if (wr_en && index == can_irq_pkg::IDX_RXPEND) begin
            rmp_next = rmp_reg & ~wdat[can_irq_pkg::RMP_LSB +: 4];
        end
        ta_next  = ta_next | core_evt.ta_set;
        rmp_next = rmp_next | core_evt.rmp_set;

        if (wr_en && index == can_irq_pkg::IDX_MASK) begin
            mask_next = wdat & can_irq_pkg::MASK_WMASK;
        end

        // Configuration request and its enable handshake
        if (wr_en && index == can_irq_pkg::IDX_CTRL) begin
            ccr_next  = wdat[can_irq_pkg::BIT_CCR];
            pdr_next  = wdat[can_irq_pkg::BIT_PDR];
            wake_on_activity_next = wdat[can_irq_pkg::BIT_WAKE_ON_ACTIVITY];
            clr_next  = wdat[can_irq_pkg::BIT_CCR] & ~ccr_reg;
        end
        if (!ccr_reg) begin
            cce_next = 1'b0;
        end else if (core_evt.bus_idle) begin
            cce_next = 1'b1;
        end

        // Power-down sequence; error counters are never cleared on wake
        case (pd_reg)
            can_irq_pkg::PD_RUN: begin
                if (pdr_reg) begin
                    pd_next = can_irq_pkg::PD_DRAIN;
                end
            end
            can_irq_pkg::PD_DRAIN: begin
                if (!pdr_reg) begin
                    pd_next = can_irq_pkg::PD_RUN;
                end else if (!core_evt.tx_active) begin
                    pd_next  = can_irq_pkg::PD_SLEEP;
                    pda_next = 1'b1;
                end
            end
            can_irq_pkg::PD_SLEEP: begin
                // Hardware wake clear wins over a host write in the same cycle
                if ((rx_dominant && wake_on_activity_reg) || !pdr_reg) begin
                    pdr_next    = 1'b0;
                    pda_next    = 1'b0;
                    recess_next = 4'h0;
                    pd_next     = can_irq_pkg::PD_RESYNC;
                end
            end
            can_irq_pkg::PD_RESYNC: begin
                if (rx_dominant) begin
                    recess_next = 4'h0;
                end else if (core_evt.bit_tick) begin
                    recess_next = recess_reg + 4'h1;
                    if (recess_next == can_irq_pkg::RECESSIVE_RUN) begin
                        pd_next = can_irq_pkg::PD_RUN;
                    end
                end
            end
            default: pd_next = can_irq_pkg::PD_RUN;
        endcase

        // Registered request lines, active low toward the expansion controller
        // Flops hold the pin level itself, so no gate sits between flop and pin
        mirq_next = ~|(flag_reg[can_irq_pkg::MBX_LSB +: 6] &
                       mask_reg[can_irq_pkg::MBX_LSB +: 6]);
        eirq_next = ~|(flag_reg[can_irq_pkg::ERR_N-1:0] &
                       mask_reg[can_irq_pkg::ERR_N-1:0]);
        mpri_next = ~mask_reg[can_irq_pkg::BIT_MBX_PRIO];
        epri_next = ~mask_reg[can_irq_pkg::BIT_ERR_PRIO];
        ok_next   = ccr_reg & cce_reg;
        act_next  = (pd_reg == can_irq_pkg::PD_RUN) & ~ccr_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_reg    <= 16'h0000;
            mask_reg    <= 16'h0000;
            ta_reg      <= 4'h0;
            rmp_reg     <= 4'h0;
            ccr_reg     <= 1'b1;
            cce_reg     <= 1'b1;
            pdr_reg     <= 1'b0;
            pda_reg     <= 1'b0;
            wake_on_activity_reg    <= 1'b0;
            recess_reg  <= 4'h0;
            pd_reg      <= can_irq_pkg::PD_RUN;
            busoff_reg  <= 1'b0;
            passive_reg <= 1'b0;
            mirq_reg    <= 1'b1;
            eirq_reg    <= 1'b1;
            mpri_reg    <= 1'b1;
            epri_reg    <= 1'b1;
            ok_reg      <= 1'b1;
            act_reg     <= 1'b0;
            clr_reg     <= 1'b0;
        end else begin
            flag_reg    <= flag_next;
            mask_reg    <= mask_next;
            ta_reg      <= ta_next;
            rmp_reg     <= rmp_next;
            ccr_reg     <= ccr_next;
            cce_reg     <= cce_next;
            pdr_reg     <= pdr_next;
            pda_reg     <= pda_next;
            wake_on_activity_reg    <= wake_on_activity_next;
            recess_reg  <= recess_next;
            pd_reg      <= pd_next;
            busoff_reg  <= core_evt.busoff;
            passive_reg <= core_evt.passive;
            mirq_reg    <= mirq_next;
            eirq_reg    <= eirq_next;
            mpri_reg    <= mpri_next;
            epri_reg    <= epri_next;
            ok_reg      <= ok_next;
            act_reg     <= act_next;
            clr_reg     <= clr_next;
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign mailbox_irq_line_n = mirq_reg;
    assign error_irq_line_n   = eirq_reg;
    assign mailbox_prio_line  = mpri_reg;
    assign error_prio_line    = epri_reg;
    assign bitcfg_write_ok    = ok_reg;
    assign bus_active         = act_reg;
    assign err_cnt_clear      = clr_reg;

    // Checks next to the logic they guard
    property p_mbx_line;
        @(posedge sys_clk) disable iff (rst)
        |(flag_reg[13:8] & mask_reg[13:8]) |=> !mailbox_irq_line_n;
    endproperty
    a_mbx_line: assert property (p_mbx_line) else $error("mailbox request missing");

    property p_err_line;
        @(posedge sys_clk) disable iff (rst)
        (flag_reg[6:0] & mask_reg[6:0]) == 7'h00 |=> error_irq_line_n;
    endproperty
    a_err_line: assert property (p_err_line) else $error("error request without cause");

    property p_prio;
        @(posedge sys_clk) disable iff (rst)
        ##1 (mailbox_prio_line == !$past(mask_reg[15])) && (error_prio_line == !$past(mask_reg[7]));
    endproperty
    a_prio: assert property (p_prio) else $error("priority line wrong");

    property p_ack_keeps;
        @(posedge sys_clk) disable iff (rst)
        irq_ack && !(wr_en && index == can_irq_pkg::IDX_FLAG) && !wr_en
        |=> (flag_reg & $past(flag_reg)) == $past(flag_reg);
    endproperty
    a_ack_keeps: assert property (p_ack_keeps) else $error("flag lost on acknowledge");

    property p_warn;
        @(posedge sys_clk) disable iff (rst)
        core_evt.tec >= 8'h60 |=> flag_reg[0] ##1 !error_irq_line_n || !$past(mask_reg[0]);
    endproperty
    a_warn: assert property (p_warn) else $error("warning flag not set");

    property p_mbx_hold;
        @(posedge sys_clk) disable iff (rst)
        flag_reg[8] && !(wr_en && index == can_irq_pkg::IDX_RXPEND) |=> flag_reg[8];
    endproperty
    a_mbx_hold: assert property (p_mbx_hold) else $error("mailbox flag cleared wrongly");

    property p_drain;
        @(posedge sys_clk) disable iff (rst)
        pd_reg == can_irq_pkg::PD_DRAIN && core_evt.tx_active |=> !pda_reg;
    endproperty
    a_drain: assert property (p_drain) else $error("acknowledge during transmission");

    property p_wake;
        @(posedge sys_clk) disable iff (rst)
        pd_reg == can_irq_pkg::PD_SLEEP && rx_dominant && wake_on_activity_reg
        |=> flag_reg[3] && !pdr_reg && !pda_reg ##1 !bus_active;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up handling wrong");

endmodule

/* design/can_irq_pkg.sv */
// Package for the interrupt, configuration and power-down control block.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package can_irq_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_FLAG    = 16'h7109;
    localparam logic [15:0] IDX_MASK    = 16'h710a;
    localparam logic [15:0] IDX_CTRL    = 16'h7100;
    localparam logic [15:0] IDX_STATUS  = 16'h7101;
    localparam logic [15:0] IDX_TXACK   = 16'h7102;
    localparam logic [15:0] IDX_RXPEND  = 16'h7103;

    // Flag and mask field layout
    localparam int MBX_LSB      = 8;
    localparam int MBX_N        = 6;
    localparam int ERR_N        = 7;
    localparam int BIT_WARN     = 0;
    localparam int BIT_PASSIVE  = 1;
    localparam int BIT_BUSOFF   = 2;
    localparam int BIT_WAKE     = 3;
    localparam int BIT_WDENY    = 4;
    localparam int BIT_ABORT    = 5;
    localparam int BIT_LOST     = 6;
    localparam int BIT_ERR_PRIO = 7;
    localparam int BIT_MBX_PRIO = 15;
    localparam logic [15:0] FLAG_WMASK = 16'h3f7f;
    localparam logic [15:0] MASK_WMASK = 16'hbfff;

    // Control and status field layout
    localparam int BIT_CCR  = 12;
    localparam int BIT_PDR  = 11;
    localparam int BIT_WAKE_ON_ACTIVITY = 9;
    localparam int BIT_CCE  = 4;
    localparam int BIT_PDA  = 3;
    localparam int TA_LSB   = 12;
    localparam int RMP_LSB  = 4;

    // Error counter warning level and idle bits before going bus-active
    localparam logic [7:0] WARN_LEVEL    = 8'h60;
    localparam logic [3:0] RECESSIVE_RUN = 4'hb;

    // Events and levels from the protocol engine, same clock
    typedef struct packed {
        logic [3:0] ta_set;
        logic [3:0] rmp_set;
        logic       msg_lost;
        logic       write_denied;
        logic       abort_done;
        logic       busoff;
        logic       passive;
        logic       tx_active;
        logic       bus_idle;
        logic       bit_tick;
        logic [7:0] tec;
        logic [7:0] rec;
    } core_evt_t;

    typedef enum logic [1:0] {PD_RUN, PD_DRAIN, PD_SLEEP, PD_RESYNC} pd_state_t;

endpackage

/* verification/irq_ack_model.sv */
// Interrupt controller stand-in that acknowledges each new request.
// Assumes active-low request lines that are sampled on sys_clk.
`timescale 1ns/10ps
module irq_ack_model #(
    parameter int DELAY = 2
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic mailbox_irq_line_n,
    input  wire logic error_irq_line_n,
    output logic      irq_ack
);
    logic       req_prev_reg;
    logic [7:0] wait_reg;
    // One ack per new request; a line held low is not acked again
    always_ff @(posedge sys_clk) begin
        req_prev_reg <= rst ? 1'b0 : !(mailbox_irq_line_n && error_irq_line_n);
        irq_ack      <= rst ? 1'b0 : (wait_reg == 8'h01);
        if (rst)
            wait_reg <= 8'h00;
        else if (!req_prev_reg && !(mailbox_irq_line_n && error_irq_line_n))
            wait_reg <= DELAY[7:0];
        else if (wait_reg != 8'h00)
            wait_reg <= wait_reg - 8'h01;
    end
endmodule

/* verification/tb.sv */
// Self-checking bench for the irq, config and power-down block.
// Assumes the package register indices and a one-cycle APB access phase.
`timescale 1ns/10ps
module tb;
    localparam logic [15:0] fl = can_irq_pkg::IDX_FLAG;
    localparam logic [15:0] mk = can_irq_pkg::IDX_MASK;
    localparam logic [15:0] ct = can_irq_pkg::IDX_CTRL;
    localparam logic [15:0] st = can_irq_pkg::IDX_STATUS;
    localparam logic [15:0] ta = can_irq_pkg::IDX_TXACK;
    localparam logic [15:0] rp = can_irq_pkg::IDX_RXPEND;
    localparam can_irq_pkg::core_evt_t ev_idle = '{bus_idle: 1'b1, default: '0};
    logic                   sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic                   can_rx, irq_ack, mb_n, mb_pri, er_n, er_pri, cfg_ok, bus_act;
    logic                   cnt_clr;
    logic [31:0]            paddr, pwdata, prdata, exp_q[$];
    logic [15:0]            rnd, v, ef;
    can_irq_pkg::core_evt_t ev;
    int                     fail_count, compares;

    can_irq_ctrl uut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_evt(ev), .can_rx(can_rx), .irq_ack(irq_ack),
        .mailbox_irq_line_n(mb_n), .mailbox_prio_line(mb_pri), .error_irq_line_n(er_n),
        .error_prio_line(er_pri), .bitcfg_write_ok(cfg_ok), .bus_active(bus_act),
        .err_cnt_clear(cnt_clr));
    irq_ack_model #(.DELAY(3)) ack (.sys_clk(sys_clk), .rst(rst),
        .mailbox_irq_line_n(mb_n), .error_irq_line_n(er_n), .irq_ack(irq_ack));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic chk1(input string name, input logic seen, input logic exp);
        check(name, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {14'h0000, idx, 2'b00};
        pwdata  <= d;
        if (!wr)
            exp_q.push_back(exp);
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        chk1("pslverr", pslverr, err);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, exp, 1'b0);
    endtask
    // One-cycle error event by flag bit; 7 is a counter just below warning
    task automatic pulse(input int b);
        @(posedge sys_clk);
        case (b)
            1: ev.passive <= 1'b1;
            2: ev.busoff <= 1'b1;
            5: ev.abort_done <= 1'b1;
            6: ev.msg_lost <= 1'b1;
            7: ev.rec <= 8'h5f;
            default: ev.tec <= 8'h60;
        endcase
        @(posedge sys_clk);
        ev <= ev_idle;
    endtask
    task automatic final_report;
        $display("Compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Read data matched against the oldest pending note
    always @(posedge sys_clk)
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            check("prdata", prdata, exp_q.pop_front());

    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        final_report;
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        can_rx = 1'b1;
        ev = ev_idle;
        fail_count = 0;
        compares = 0;
        void'($urandom(32'h67328300));
        tick(5);
        rst <= 1'b0;
        tick(1);
        chk1("mb_n", mb_n, 1'b1);
        chk1("er_pri", er_pri, 1'b1);
        chk1("cfg_ok", cfg_ok, 1'b1);
        chk1("cnt_clr", cnt_clr, 1'b0);
        rd(st, 32'h0010);
        rd(ct, 32'h1000);
        rd(fl, 32'h0000);
        apb(1'b0, 16'h7108, 32'h0, 32'h0, 1'b1);
        // Random masks, then the same with both priority bits flipped
        rnd = 16'($urandom());
        for (int i = 0; i < 2; i++) begin
            v = rnd ^ (i == 1 ? 16'h8080 : 16'h0000);
            wr(mk, {16'h0000, v});
            rd(mk, {16'h0000, v & can_irq_pkg::MASK_WMASK});
            chk1("mb_pri", mb_pri, !v[15]);
            chk1("er_pri", er_pri, !v[7]);
        end
        // Mailboxes 4 and 5 masked off, mailboxes 0 and 2-5 complete at once
        wr(mk, 32'h0f00);
        @(posedge sys_clk);
        ev.ta_set <= 4'hf;
        ev.rmp_set <= 4'h1;
        @(posedge sys_clk);
        ev <= ev_idle;
        rd(fl, 32'h0d00);
        rd(ta, 32'hf000);
        chk1("mb_n", mb_n, 1'b0);
        wr(fl, 32'hffff);
        rd(fl, 32'h0d00);
        wr(ta, 32'hf000);
        rd(fl, 32'h0100);
        chk1("mb_n", mb_n, 1'b0);
        wr(rp, 32'h0010);
        rd(rp, 32'h0000);
        chk1("mb_n", mb_n, 1'b1);
        // Error flag set while masked reaches the line once unmasked
        wr(mk, 32'h0000);
        @(posedge sys_clk);
        ev.write_denied <= 1'b1;
        @(posedge sys_clk);
        ev <= ev_idle;
        rd(fl, 32'h0010);
        chk1("er_n", er_n, 1'b1);
        wr(mk, 32'h0010);
        tick(2);
        chk1("er_n", er_n, 1'b0);
        ef = 16'h0010;
        foreach (ef[b]) if (b == 7 || b == 0 || b == 1 || b == 2 || b == 5 || b == 6) begin
            pulse(b);
            ef = ef | ((b == 7) ? 16'h0000 : (16'h0001 << b));
            rd(fl, {16'h0000, ef});
        end
        tick(6);
        rd(fl, {16'h0000, ef});
        wr(mk, 32'h007f);
        wr(fl, 32'h0010);
        rd(fl, {16'h0000, ef & 16'hffef});
        chk1("er_n", er_n, 1'b0);
        wr(fl, 32'h007f);
        tick(2);
        chk1("er_n", er_n, 1'b1);
        // Event and write-one clear land on the same edge
        fork
            wr(fl, 32'h0040);
            begin
                tick(2);
                ev.msg_lost <= 1'b1;
                tick(1);
                ev.msg_lost <= 1'b0;
            end
        join
        rd(fl, 32'h0040);
        wr(fl, 32'h0040);
        // Leaving configuration, then re-entering it while the bus is busy
        wr(ct, 32'h0000);
        rd(st, 32'h0000);
        chk1("cfg_ok", cfg_ok, 1'b0);
        chk1("bus_act", bus_act, 1'b1);
        ev.bus_idle <= 1'b0;
        wr(ct, 32'h1000);
        tick(1);
        chk1("cnt_clr", cnt_clr, 1'b1);
        tick(2);
        rd(st, 32'h0000);
        ev.bus_idle <= 1'b1;
        tick(2);
        rd(st, 32'h0010);
        // Host requests power-down mid-transmission, then polls
        wr(ct, 32'h0000);
        ev.tx_active <= 1'b1;
        wr(ct, 32'h0a00);
        tick(4);
        rd(st, 32'h0000);
        ev.tx_active <= 1'b0;
        tick(3);
        rd(st, 32'h0008);
        can_rx <= 1'b0;
        tick(4);
        can_rx <= 1'b1;
        tick(2);
        rd(fl, 32'h0008);
        rd(ct, 32'h0200);
        rd(st, 32'h0000);
        repeat (10) begin
            @(posedge sys_clk);
            ev.bit_tick <= 1'b1;
            @(posedge sys_clk);
            ev.bit_tick <= 1'b0;
        end
        tick(2);
        chk1("bus_act", bus_act, 1'b0);
        ev.bit_tick <= 1'b1;
        tick(1);
        ev.bit_tick <= 1'b0;
        tick(3);
        chk1("bus_act", bus_act, 1'b1);
        // Without wake-on-activity the host leaves power-down itself
        wr(ct, 32'h0800);
        tick(3);
        rd(st, 32'h0008);
        wr(ct, 32'h0000);
        tick(2);
        rd(st, 32'h0000);
        tick(5);
        final_report;
    end
endmodule
